/* File: dmem_pkg.sv */
// dmem_pkg: constants and carriers for the sectored data memory
// assumes a single clock domain shared with the cpu core
package dmem_pkg;

  localparam int DATA_W = 8;
  localparam int SECT_W = 1;
  localparam int LOC_W = 8;
  localparam int ADDR_W = SECT_W + LOC_W;
  localparam int GP_W = 7;
  localparam int GP_DEPTH = 256;

  localparam logic [7:0] SFR_LAST = 8'h7f;
  localparam logic [7:0] GP_FIRST = 8'h80;
  localparam logic [7:0] UNUSED_VAL = 8'h00;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // pointer locations within sector 0
  localparam logic [7:0] LOC_PTR_A_ADDR = 8'h03;
  localparam logic [7:0] SECT_PTR_A_ADDR = 8'h04;
  localparam logic [7:0] LOC_PTR_B_ADDR = 8'h0d;
  localparam logic [7:0] SECT_PTR_B_ADDR = 8'h0e;
  // protected read-only location (stack pointer view)
  localparam logic [7:0] RO_ADDR = 8'h71;
  localparam logic [7:0] RO_FIELD_MASK = 8'h07;
  // last sfr location backed by storage in sector 0
  localparam logic [7:0] SFR_USED_LAST = 8'h71;

  typedef enum logic [1:0]
  {
    MODE_STD = 2'b00,
    MODE_EXT = 2'b01,
    MODE_IND_A = 2'b11,
    MODE_IND_B = 2'b10
  } addr_mode_e;

  typedef enum logic [1:0]
  {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_BSET = 2'b11,
    OP_BCLR = 2'b10
  } op_e;

  typedef struct packed
  {
    logic valid;
    op_e op;
    addr_mode_e mode;
    logic [ADDR_W-1:0] addr;
    logic [2:0] bit_sel;
    logic [DATA_W-1:0] wdata;
  } mem_req_s;

  typedef struct packed
  {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } mem_rsp_s;

endpackage

/* File: gp_ram.sv */
// gp_ram: general purpose storage, one 8-bit word per location
// assumes writes and reads come from one clocked client
`timescale 1ns/1ps
module gp_ram
(
  // clock only, no reset
  input wire logic ref_clk_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [dmem_pkg::ADDR_W-2:0] wr_addr_in,
  input wire logic [dmem_pkg::DATA_W-1:0] wr_data_in,
  // read port
  input wire logic [dmem_pkg::ADDR_W-2:0] rd_addr_in,
  output logic [dmem_pkg::DATA_W-1:0] rd_data_out
);
  import dmem_pkg::*;

  logic [DATA_W-1:0] mem [GP_DEPTH];

  // plain ram, no reset: contents are undefined until written
  always_ff @(posedge ref_clk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule

/* File: sectored_data_memory.sv */
// sectored_data_memory: special function and general purpose data memory
// assumes the core holds a request for one cycle; answer follows 2 cycles
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Operation
// - every sector is 8-bit ram; each access moves one byte
// - locations 00h..7fh of a sector decode as special function area
// - locations 80h..ffh of a sector decode as general storage
// - no bank pointer; sector comes from pointers or extended address
// - indirect: sector from high pointer, location from its low partner
// - extended address carries 9 significant bits
// - extended address: top bit sector, low byte location
// - standard accesses reach only sector 0; extended reach all
// - direct addressing works in every sector via extended form
// - general locations are freely readable and writable
// - single bit set and clear leave other bits unchanged
// - sfrs fixed; most read/write, protected ones ignore writes
// - unused special function locations read as 00h
module sectored_data_memory
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // access request from the core
  input wire dmem_pkg::mem_req_s req_in,
  // protected status fed by the core
  input wire logic [2:0] ro_status_in,
  // answer to the core
  output dmem_pkg::mem_rsp_s rsp_out,
  // pointer values for observation
  output logic [dmem_pkg::DATA_W-1:0] sector_pointer_a_out,
  output logic [dmem_pkg::DATA_W-1:0] sector_pointer_b_out,
  output logic [dmem_pkg::DATA_W-1:0] location_pointer_a_out,
  output logic [dmem_pkg::DATA_W-1:0] location_pointer_b_out
);
  import dmem_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // address resolution

  logic [ADDR_W-1:0] eff_addr;
  logic [LOC_W-1:0] loc;
  logic is_gp;
  logic [ADDR_W-1:0] ptr_a_addr;
  logic [ADDR_W-1:0] ptr_b_addr;
  logic [DATA_W-1:0] sector_pointer_a;
  logic [DATA_W-1:0] sector_pointer_b;
  logic [DATA_W-1:0] location_pointer_a;
  logic [DATA_W-1:0] location_pointer_b;

  // only the low sector bit of each high pointer is significant
  assign ptr_a_addr = {sector_pointer_a[SECT_W-1:0], location_pointer_a};
  assign ptr_b_addr = {sector_pointer_b[SECT_W-1:0], location_pointer_b};

  // choose the full address; no separate bank register exists
  always_comb
  begin
    case (req_in.mode)
      MODE_STD: eff_addr = {{SECT_W{1'b0}}, req_in.addr[LOC_W-1:0]};
      MODE_EXT: eff_addr = req_in.addr;
      MODE_IND_A: eff_addr = ptr_a_addr;
      MODE_IND_B: eff_addr = ptr_b_addr;
      default: eff_addr = {{SECT_W{1'b0}}, req_in.addr[LOC_W-1:0]};
    endcase
  end

  assign loc = eff_addr[LOC_W-1:0];
  assign is_gp = (loc >= GP_FIRST);

  ////////////////////////////////////////////////////////////////////////
  // sfr storage: sector 0 only, other sectors hold unused sfr space

  logic [DATA_W-1:0] sfr [int'(SFR_USED_LAST)+1];
  logic [DATA_W-1:0] next_sfr [int'(SFR_USED_LAST)+1];
  logic sfr_hit;
  logic [DATA_W-1:0] sfr_old;

  // sfrs exist only in sector 0; a reading of sfr space elsewhere is 00h
  assign sfr_hit = !is_gp && (eff_addr[ADDR_W-1:LOC_W] == '0)
    && (loc <= SFR_USED_LAST);

  always_comb
  begin
    sfr_old = UNUSED_VAL;
    if (sfr_hit)
    begin
      sfr_old = (loc == RO_ADDR) ? {5'h00, ro_status_in} : sfr[loc[GP_W-1:0]];
    end
  end

  // modified byte for write and bit ops; whole-byte, one bit changed
  function automatic logic [DATA_W-1:0] modify
  (
    input op_e op,
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] wd,
    input logic [2:0] b
  );
    logic [DATA_W-1:0] m;
    m = 8'h01 << b;
    case (op)
      OP_WRITE: modify = wd;
      OP_BSET: modify = old | m;
      OP_BCLR: modify = old & ~m;
      default: modify = old;
    endcase
  endfunction

  logic is_write;
  logic busy;
  // requests that arrive while an access is in flight are dropped
  assign is_write = req_in.valid && !busy && (req_in.op != OP_READ);

  // next sfr contents; the protected location ignores program writes
  genvar gi;
  generate
    for (gi = 0; gi <= int'(SFR_USED_LAST); gi++)
    begin : g_sfr
      always_comb
      begin
        next_sfr[gi] = sfr[gi];
        if (is_write && sfr_hit && (loc[GP_W-1:0] == GP_W'(gi))
          && (loc != RO_ADDR))
        begin
          next_sfr[gi] = modify(req_in.op, sfr_old, req_in.wdata,
            req_in.bit_sel);
        end
      end

      always_ff @(posedge ref_clk_in)
      begin
        if (!rst_b_in)
        begin
          sfr[gi] <= RESET_VAL;
        end
        else
        begin
          sfr[gi] <= next_sfr[gi];
        end
      end
    end
  endgenerate

  assign sector_pointer_a = sfr[SECT_PTR_A_ADDR[GP_W-1:0]];
  assign sector_pointer_b = sfr[SECT_PTR_B_ADDR[GP_W-1:0]];
  assign location_pointer_a = sfr[LOC_PTR_A_ADDR[GP_W-1:0]];
  assign location_pointer_b = sfr[LOC_PTR_B_ADDR[GP_W-1:0]];

  ////////////////////////////////////////////////////////////////////////
  // general storage: bit ops need the old byte, so they run in two steps

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_RMW = 2'b01,
    ST_REPLY = 2'b11
  } gp_state_e;

  gp_state_e state;
  gp_state_e next_state;
  mem_req_s held;
  mem_req_s next_held;
  logic [ADDR_W-1:0] held_addr;
  logic [ADDR_W-1:0] next_held_addr;
  logic held_gp;
  logic next_held_gp;
  logic [DATA_W-1:0] held_sfr;
  logic [DATA_W-1:0] next_held_sfr;
  logic ram_we;
  logic [ADDR_W-2:0] ram_waddr;
  logic [DATA_W-1:0] ram_wdata;
  logic [DATA_W-1:0] ram_rdata;
  mem_rsp_s next_rsp;

  assign busy = (state != ST_IDLE);

  // ram index: sector bit over the seven low location bits
  function automatic logic [ADDR_W-2:0] gp_index(input logic [ADDR_W-1:0] a);
    gp_index = {a[ADDR_W-1:LOC_W], a[GP_W-1:0]};
  endfunction

  gp_ram u_gp_ram
  (
    .ref_clk_in(ref_clk_in),
    .wr_en_in(ram_we),
    .wr_addr_in(ram_waddr),
    .wr_data_in(ram_wdata),
    .rd_addr_in(gp_index(eff_addr)),
    .rd_data_out(ram_rdata)
  );

  // every request is answered one cycle after it was taken
  always_comb
  begin
    next_state = state;
    next_held = held;
    next_held_addr = held_addr;
    next_held_gp = held_gp;
    next_held_sfr = held_sfr;
    next_rsp = '0;
    ram_we = 1'b0;
    ram_waddr = gp_index(held_addr);
    ram_wdata = held.wdata;
    case (state)
      ST_IDLE:
      begin
        if (req_in.valid)
        begin
          next_held = req_in;
          next_held_addr = eff_addr;
          next_held_gp = is_gp;
          next_held_sfr = sfr_old;
          next_state = ST_RMW;
        end
      end
      ST_RMW:
      begin
        // no protection on general storage
        ram_we = held_gp && (held.op != OP_READ);
        ram_wdata = modify(held.op, ram_rdata, held.wdata, held.bit_sel);
        next_state = ST_REPLY;
        next_rsp.valid = 1'b1;
        next_rsp.rdata = held_gp ? ram_rdata : held_sfr;
      end
      ST_REPLY:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state registers for the access sequence
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      state <= ST_IDLE;
      held <= '0;
      held_addr <= '0;
      held_gp <= 1'b0;
      held_sfr <= RESET_VAL;
      rsp_out <= '0;
      sector_pointer_a_out <= RESET_VAL;
      sector_pointer_b_out <= RESET_VAL;
      location_pointer_a_out <= RESET_VAL;
      location_pointer_b_out <= RESET_VAL;
    end
    else
    begin
      state <= next_state;
      held <= next_held;
      held_addr <= next_held_addr;
      held_gp <= next_held_gp;
      held_sfr <= next_held_sfr;
      rsp_out <= next_rsp;
      sector_pointer_a_out <= next_sfr[SECT_PTR_A_ADDR[GP_W-1:0]];
      sector_pointer_b_out <= next_sfr[SECT_PTR_B_ADDR[GP_W-1:0]];
      location_pointer_a_out <= next_sfr[LOC_PTR_A_ADDR[GP_W-1:0]];
      location_pointer_b_out <= next_sfr[LOC_PTR_B_ADDR[GP_W-1:0]];
    end
  end

endmodule

/* File: dmem_monitor.sv */
// dmem_monitor: timing and decode checks on the data memory ports
// assumes the core leaves at least 3 cycles between requests
`timescale 1ns/1ps
module dmem_monitor
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // core side
  input wire dmem_pkg::mem_req_s req_in,
  input wire logic [2:0] ro_status_in,
  input wire dmem_pkg::mem_rsp_s rsp_out,
  // pointer views
  input wire logic [7:0] sector_pointer_a_out,
  input wire logic [7:0] sector_pointer_b_out,
  input wire logic [7:0] location_pointer_a_out,
  input wire logic [7:0] location_pointer_b_out
);
  import dmem_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////
  // answers: exactly two edges after a fresh request, never stray
  a_answer_timing:
    assert property (req_in.valid && !$past(req_in.valid) &&
      !$past(req_in.valid, 2) |-> !rsp_out.valid[*2] ##1 rsp_out.valid)
    else $error("answer not two cycles after request");
  a_no_stray:
    assert property (rsp_out.valid |-> $past(req_in.valid, 2))
    else $error("answer without request");
  // decode of empty and protected sfr space
  a_unused_zero:
    assert property (req_in.valid && (req_in.mode == MODE_STD ||
      (req_in.mode == MODE_EXT && !req_in.addr[8])) &&
      req_in.addr[7:0] > SFR_USED_LAST && req_in.addr[7:0] <= SFR_LAST
      |-> ##2 rsp_out.rdata == UNUSED_VAL)
    else $error("unused sfr not zero");
  a_sector_one_sfr:
    assert property (req_in.valid && req_in.mode == MODE_EXT &&
      req_in.addr[8] && !req_in.addr[7] |-> ##2 rsp_out.rdata == 8'h00)
    else $error("sector one sfr not zero");
  a_ro_upper_zero:
    assert property (req_in.valid && (req_in.mode == MODE_STD ||
      (req_in.mode == MODE_EXT && !req_in.addr[8])) &&
      req_in.addr[7:0] == RO_ADDR
      |-> ##2 rsp_out.rdata == {5'h00, $past(ro_status_in, 2)})
    else $error("protected location value wrong");
  // views: sector a and location b follow writes, sector b and location a hold otherwise
  a_ptr_a_write:
    assert property (req_in.valid && req_in.op == OP_WRITE &&
      req_in.mode == MODE_STD && req_in.addr[7:0] == SECT_PTR_A_ADDR
      |-> ##2 sector_pointer_a_out == $past(req_in.wdata, 2))
    else $error("sector pointer a not written");
  a_ptr_b_write:
    assert property (req_in.valid && req_in.op == OP_WRITE &&
      req_in.mode == MODE_STD && req_in.addr[7:0] == LOC_PTR_B_ADDR
      |-> ##2 location_pointer_b_out == $past(req_in.wdata, 2))
    else $error("location pointer b not written");
  a_ptr_stable:
    assert property (!$past(req_in.valid) && !$past(req_in.valid, 2)
      |-> $stable(sector_pointer_b_out) && $stable(location_pointer_a_out))
    else $error("pointer moved without access");
  a_reset_clear:
    assert property (disable iff (1'b0) !rst_b_in |=> !rsp_out.valid &&
      sector_pointer_a_out == RESET_VAL)
    else $error("reset did not clear");
  // main scenarios
  c_ind_a: cover property (req_in.valid && req_in.mode == MODE_IND_A);
  c_bset: cover property (req_in.valid && req_in.op == OP_BSET);
  c_ro: cover property (req_in.valid && req_in.addr[7:0] == RO_ADDR);
endmodule
bind sectored_data_memory dmem_monitor mon (.ref_clk_in, .rst_b_in,
  .req_in, .ro_status_in, .rsp_out, .sector_pointer_a_out,
  .sector_pointer_b_out, .location_pointer_a_out, .location_pointer_b_out);

/* File: cpu_core_model.sv */
// cpu_core_model: issues one data memory access at a time
// assumes the answer comes on the first edge after the taking edge
`timescale 1ns/1ps
module cpu_core_model
(
  // clock
  input wire logic ref_clk_in,
  // memory side
  output dmem_pkg::mem_req_s req_out,
  input wire dmem_pkg::mem_rsp_s rsp_in
);
  import dmem_pkg::*;
  ////////////////////////////////////////
  initial req_out = '0;
  // released fields are inverted so stale values are never reused
  task automatic xfer(input op_e op, input addr_mode_e md,
    input logic [8:0] a, input logic [2:0] b, input logic [7:0] wd,
    output logic [7:0] rd, output logic ok);
    @(negedge ref_clk_in);
    req_out <= {1'b1, op, md, a, b, wd};
    @(negedge ref_clk_in);
    req_out <= {1'b0, ~{op, md, a, b, wd}};
    // the answer stands between the first and second edge after taking
    @(negedge ref_clk_in);
    ok = rsp_in.valid;
    rd = rsp_in.rdata;
  endtask
endmodule

/* File: testbench.sv */
// testbench: random and corner accesses against a byte model
// assumes the core model spaces requests by three cycles
`timescale 1ns/1ps
module testbench;
  import dmem_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [2:0] ro = 3'h0;
  mem_req_s req;
  mem_rsp_s rsp;
  logic [7:0] spa, spb, lpa, lpb;
  logic [7:0] mem [512];
  logic [8:0] a;
  addr_mode_e m;
  op_e rand_op;
  int fail_count = 0;
  int cmp_count = 0;
  cpu_core_model core (.ref_clk_in, .req_out(req), .rsp_in(rsp));
  sectored_data_memory uut (.ref_clk_in, .rst_b_in, .req_in(req),
    .ro_status_in(ro), .rsp_out(rsp), .sector_pointer_a_out(spa),
    .sector_pointer_b_out(spb), .location_pointer_a_out(lpa),
    .location_pointer_b_out(lpb));
  ////////////////////////////////////////
  // free running clock
  initial forever #5 ref_clk_in = ~ref_clk_in;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // storage that keeps writes: general space and sfrs up to 70h
  function automatic bit kept(logic [8:0] e);
    return e[7] || (!e[8] && e[7:0] < RO_ADDR);
  endfunction
  // resolve the full address the way the core's mode asks
  function automatic logic [8:0] eff(addr_mode_e md, logic [8:0] x);
    if (md == MODE_STD) return {1'b0, x[7:0]};
    if (md == MODE_IND_A)
      return {mem[SECT_PTR_A_ADDR][0], mem[LOC_PTR_A_ADDR]};
    if (md == MODE_IND_B)
      return {mem[SECT_PTR_B_ADDR][0], mem[LOC_PTR_B_ADDR]};
    return x;
  endfunction
  task automatic op(input op_e o, input addr_mode_e md, input logic [8:0] x,
    input logic [2:0] b, input logic [7:0] wd, input bit chk);
    logic [8:0] e;
    logic [7:0] old, rd;
    logic ok;
    e = eff(md, x);
    old = kept(e) ? mem[e] : UNUSED_VAL;
    if (e == {1'b0, RO_ADDR}) old = {5'h00, ro};
    core.xfer(o, md, x, b, wd, rd, ok);
    check({7'h00, ok}, 8'h01);
    if (chk) check(rd, old);
    if (kept(e) && o == OP_WRITE) mem[e] = wd;
    if (kept(e) && o == OP_BSET) mem[e] = old | (8'h01 << b);
    if (kept(e) && o == OP_BCLR) mem[e] = old & ~(8'h01 << b);
  endtask
  // plain write to a sector-0 sfr, checking the byte it replaces
  task automatic wr_sfr(input logic [7:0] l, input logic [7:0] v);
    op(OP_WRITE, MODE_STD, {1'b0, l}, 3'h0, v, 1'b1);
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'h60a39161));
    for (int i = 0; i < 512; i++) mem[i] = (i < 128) ? 8'h00 : 8'hxx;
    repeat (12) @(negedge ref_clk_in);
    rst_b_in <= 1'b1;
    check(spa | spb | lpa | lpb, RESET_VAL);
    for (int i = 128; i < 512; i++)
    begin
      if (i[7])
        op(OP_WRITE, MODE_EXT, i[8:0], 3'h0, 8'($urandom), 1'b0);
    end
    repeat (80)
    begin
      a = {1'($urandom), 1'b1, 7'($urandom)};
      m = addr_mode_e'($urandom_range(0, 3));
      rand_op = op_e'($urandom_range(0, 3));
      if (m == MODE_IND_A)
      begin
        wr_sfr(LOC_PTR_A_ADDR, a[7:0]);
        wr_sfr(SECT_PTR_A_ADDR, {7'h00, a[8]});
      end
      if (m == MODE_IND_B)
      begin
        wr_sfr(LOC_PTR_B_ADDR, a[7:0]);
        wr_sfr(SECT_PTR_B_ADDR, {7'h00, a[8]});
      end
      op(rand_op, m, a, 3'($urandom), 8'($urandom), 1'b1);
    end
    check(spa, mem[SECT_PTR_A_ADDR]);
    check(spb, mem[SECT_PTR_B_ADDR]);
    check(lpa, mem[LOC_PTR_A_ADDR]);
    check(lpb, mem[LOC_PTR_B_ADDR]);
    // the protected value changes by blocking write so the model sees it
    foreach (mem[i])
    begin
      if (i[6:0] == 7'h71 || i[6:0] == 7'h7f || i[6:0] == 7'h20 ||
        i[6:0] == 7'h00)
      begin
        @(negedge ref_clk_in);
        ro = 3'($urandom);
        for (int k = 0; k < 4; k++)
        begin
          rand_op = op_e'(k);
          op(rand_op, MODE_EXT, i[8:0], 3'h2, 8'h5a, 1'b1);
        end
      end
    end
    end_of_test();
  end
  // watchdog
  initial
  begin
    #400000;
    fail_count++;
    end_of_test();
  end
endmodule
